// >>> core/sdmct_pkg.sv
// Purpose: shared constants and types of the sdram mode and command timing
// Assumes: memory cycles are ticks of a divided enable from the core clock
// Notes: pin codes are the active-low ras/cas/we triples of an sdram
package sdmct_pkg;
   // ****************************************************************
   // command set
   // ****************************************************************
   typedef enum logic [2:0] {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_PALL, CMD_REF, CMD_MRS
   } sdmct_cmd_t;
   // {ras_n, cas_n, we_n} for each command
   localparam logic [2:0] PIN_NOP = 3'h7;
   localparam logic [2:0] PIN_ACT = 3'h3;
   localparam logic [2:0] PIN_RD = 3'h5;
   localparam logic [2:0] PIN_WR = 3'h4;
   localparam logic [2:0] PIN_PRE = 3'h2;
   localparam logic [2:0] PIN_REF = 3'h1;
   localparam logic [2:0] PIN_MRS = 3'h0;
   // ****************************************************************
   // mode word
   // ****************************************************************
   localparam int MODE_W = 14;
   localparam logic [13:0] MODE_CL2 = 14'h0022;
   localparam logic [13:0] MODE_CL3 = 14'h0032;
   localparam int MODE_LAT_LSB = 4;
   localparam int MODE_SI_BIT = 3;
   localparam logic [2:0] MODE_BL4 = 3'h2;
   localparam int MODE_A10_BIT = 10;
   // address pin that feeds the memory auto-precharge input
   localparam int AUTOPRE_BIT = 10;
   localparam logic [2:0] CAS_BASE = 3'h2;
   // ****************************************************************
   // spacing counters, one index each
   // ****************************************************************
   localparam int NGAP = 14;
   localparam int G_RC = 0;
   localparam int G_RCD = 1;
   localparam int G_RP = 2;
   localparam int G_RAS = 3;
   localparam int G_RRD = 4;
   localparam int G_WR = 5;
   localparam int G_HZP = 6;
   localparam int G_READ_TO_READ_FIELD = 7;
   localparam int G_RD2PRE = 8;
   localparam int G_READ_TO_WRITE_FIELD = 9;
   localparam int G_DQM = 10;
   localparam int G_WRITE_TO_WRITE_FIELD = 11;
   localparam int G_WR2PRE = 12;
   localparam int G_WRITE_TO_READ_FIELD = 13;
   // row-to-row adds one extra cycle on top of the field
   localparam int RRD_EXTRA = 1;
   localparam int MCLK_DIV_DEF = 2;
endpackage

// >>> core/sdmct_gap_if.sv
// Purpose: carrier between the command logic and its spacing counters
// Assumes: loads and tick come from the command logic
// Notes: expired is level, high while a counter sits at zero
`timescale 1ns/1ps
`default_nettype none
interface sdmct_gap_if #(parameter int N = 14, parameter int CW = 5);
   logic tick; // memory-clock enable
   logic [N-1:0] load; // restart a counter this cycle
   logic [CW-1:0] value [N]; // value loaded on restart
   logic [N-1:0] expired; // counter has run out
   modport ctrl (output tick, output load, output value, input expired);
   modport timer (input tick, input load, input value, output expired);
endinterface
`default_nettype wire

// >>> core/sdmct_gap_timer.sv
// Purpose: bank of down-counters that hold off dependent commands
// Assumes: load is only raised together with tick
// Notes: a counter loaded with f lets its command go f+1 ticks later
`timescale 1ns/1ps
`default_nettype none
module sdmct_gap_timer #(
   parameter int N = 14,
   parameter int CW = 5
) (
   input wire logic clk,
   input wire logic rst,
   sdmct_gap_if.timer g
);
   import sdmct_pkg::*;
   // ****************************************************************
   // per-constraint counters
   // ****************************************************************
   logic [CW-1:0] cnt_q [N]; // remaining ticks
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : gap
         // load wins over counting; counting stops at zero
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               cnt_q[i] <= '0;
            end else if (g.load[i]) begin
               cnt_q[i] <= g.value[i];
            end else if (g.tick && cnt_q[i] != '0) begin
               cnt_q[i] <= cnt_q[i] - 1'b1;
            end
         end
         assign g.expired[i] = (cnt_q[i] == '0);
      end
   endgenerate
endmodule
`default_nettype wire

// >>> core/sdmct_top.sv
// Purpose: mode register programming and command spacing for sdram
// Assumes: a sequencer outside offers one command at a time
// Notes: commands are taken on memory ticks and appear on pins next cycle
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - mode value picked only by latency select
// - mode word programs burst four, sequential
// - latency select one drives 0032h
// - latency select zero drives 0022h
// - latency field bits 6-4, bit4 equals select
// - refresh holds act, mode, refresh field+1
// - activate holds read/write field+1
// - precharge holds act, mode, refresh field+1
// - read data returns select+2 cycles later
// - activate holds precharge field+1
// - activate to activate field+2
// - last write data holds precharge field+1
// - read bus floats field+1 after precharge
// - read to read field+1
// - read to precharge field+1
// - read to write field+1
// - byte enables high field+1 before write
// - write to write field+1
// - write to precharge field+1
// - write to read field+1
// - all counts in memory clock cycles
// - auto-precharge pin low on read/write
module sdmct_top #(
   parameter int FW = 4, // width of each timing field
   parameter int AW = 14, // address pins ea2 upward
   parameter int MCLK_DIV = sdmct_pkg::MCLK_DIV_DEF
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic req_valid,
   input wire sdmct_pkg::sdmct_cmd_t req_cmd,
   input wire logic [1:0] req_bank,
   input wire logic [AW-1:0] req_addr,
   output logic req_ready,
   input wire logic wr_last_data,
   input wire logic cas_latency_sel,
   input wire logic [FW-1:0] refresh_cycle_field,
   input wire logic [FW-1:0] row_to_column_field,
   input wire logic [FW-1:0] precharge_field,
   input wire logic [FW-1:0] row_active_field,
   input wire logic [FW-1:0] row_to_row_field,
   input wire logic [FW-1:0] write_recovery_field,
   input wire logic [FW-1:0] precharge_float_field,
   input wire logic [FW-1:0] read_to_read_field,
   input wire logic [FW-1:0] read_to_precharge_field,
   input wire logic [FW-1:0] read_to_write_field,
   input wire logic [FW-1:0] byte_mask_turnaround_field,
   input wire logic [FW-1:0] write_to_write_field,
   input wire logic [FW-1:0] write_to_precharge_field,
   input wire logic [FW-1:0] write_to_read_field,
   output logic memory_clock_out,
   output logic mem_cs_n,
   output logic mem_ras_n,
   output logic mem_cas_n,
   output logic mem_we_n,
   output logic [1:0] mem_ba,
   output logic [AW-1:0] mem_addr,
   output logic precharge_addr_pin,
   output logic [3:0] byte_enable_out,
   output logic rd_data_start,
   output logic read_bus_float
);
   import sdmct_pkg::*;
   localparam int CW = FW + 1;
   localparam int DW = $clog2(MCLK_DIV + 1);
   // ****************************************************************
   // memory clock divider
   // ****************************************************************
   logic [DW-1:0] div_q; // position inside one memory period
   logic tick; // one-cycle enable per memory cycle
   logic mclk_q; // registered memory clock level
   assign tick = (div_q == DW'(MCLK_DIV - 1));
   // the divider never stops, so the far side always sees a clock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_q <= '0;
      end else if (tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end
   // high in the first half of the period; commands change on its rise
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mclk_q <= 1'b0;
      end else begin
         mclk_q <= (tick || div_q < DW'(MCLK_DIV / 2 - 1));
      end
   end
   assign memory_clock_out = mclk_q;
   // ****************************************************************
   // spacing counters
   // ****************************************************************
   sdmct_gap_if #(.N(NGAP), .CW(CW)) gap_bus ();
   sdmct_gap_timer #(.N(NGAP), .CW(CW)) u_gap (
      .clk(clk),
      .rst(rst),
      .g(gap_bus)
   );
   logic [NGAP-1:0] ok; // counter at zero
   logic issue; // a command is taken this cycle
   logic is_act, is_rd, is_wr, is_pre, is_ref, is_mrs;
   logic wr_last_pend_q; // last write data seen, waiting for a tick
   assign ok = gap_bus.expired;
   assign gap_bus.tick = tick;
   assign issue = req_valid && req_ready;
   assign is_act = issue && req_cmd == CMD_ACT;
   assign is_rd = issue && req_cmd == CMD_RD;
   assign is_wr = issue && req_cmd == CMD_WR;
   assign is_pre = issue && (req_cmd == CMD_PRE || req_cmd == CMD_PALL);
   assign is_ref = issue && req_cmd == CMD_REF;
   assign is_mrs = issue && req_cmd == CMD_MRS;
   // load values: field as is, row-to-row one more
   always_comb begin
      gap_bus.value[G_RC] = CW'(refresh_cycle_field);
      gap_bus.value[G_RCD] = CW'(row_to_column_field);
      gap_bus.value[G_RP] = CW'(precharge_field);
      gap_bus.value[G_RAS] = CW'(row_active_field);
      gap_bus.value[G_RRD] = CW'(row_to_row_field) + CW'(RRD_EXTRA);
      gap_bus.value[G_WR] = CW'(write_recovery_field);
      gap_bus.value[G_HZP] = CW'(precharge_float_field);
      gap_bus.value[G_READ_TO_READ_FIELD] = CW'(read_to_read_field);
      gap_bus.value[G_RD2PRE] = CW'(read_to_precharge_field);
      gap_bus.value[G_READ_TO_WRITE_FIELD] = CW'(read_to_write_field);
      gap_bus.value[G_DQM] = CW'(byte_mask_turnaround_field);
      gap_bus.value[G_WRITE_TO_WRITE_FIELD] = CW'(write_to_write_field);
      gap_bus.value[G_WR2PRE] = CW'(write_to_precharge_field);
      gap_bus.value[G_WRITE_TO_READ_FIELD] = CW'(write_to_read_field);
   end
   // each opening command restarts the counters it guards
   always_comb begin
      gap_bus.load = '0;
      gap_bus.load[G_RC] = is_ref;
      gap_bus.load[G_RCD] = is_act;
      gap_bus.load[G_RAS] = is_act;
      gap_bus.load[G_RRD] = is_act;
      gap_bus.load[G_RP] = is_pre;
      gap_bus.load[G_HZP] = is_pre;
      gap_bus.load[G_WR] = tick && (wr_last_pend_q || wr_last_data);
      gap_bus.load[G_READ_TO_READ_FIELD] = is_rd;
      gap_bus.load[G_RD2PRE] = is_rd;
      gap_bus.load[G_READ_TO_WRITE_FIELD] = is_rd;
      gap_bus.load[G_DQM] = is_rd;
      gap_bus.load[G_WRITE_TO_WRITE_FIELD] = is_wr;
      gap_bus.load[G_WR2PRE] = is_wr;
      gap_bus.load[G_WRITE_TO_READ_FIELD] = is_wr;
   end
   // last-data pulse may land between ticks; on a tick the clear wins and the pulse loads directly
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_last_pend_q <= 1'b0;
      end else if (wr_last_data && !tick) begin
         wr_last_pend_q <= 1'b1;
      end else if (tick) begin
         wr_last_pend_q <= 1'b0;
      end
   end
   // ****************************************************************
   // admission: a command goes only when all its counters ran out
   // ****************************************************************
   always_comb begin
      case (req_cmd)
         CMD_NOP: req_ready = tick;
         CMD_ACT: req_ready = tick && ok[G_RC] && ok[G_RP] && ok[G_RRD];
         CMD_RD: req_ready = tick && ok[G_RCD] && ok[G_READ_TO_READ_FIELD] && ok[G_WRITE_TO_READ_FIELD];
         CMD_WR: req_ready = tick && ok[G_RCD] && ok[G_READ_TO_WRITE_FIELD]
                             && ok[G_WRITE_TO_WRITE_FIELD] && ok[G_DQM];
         // last data landing in this very tick holds precharge off too
         CMD_PRE, CMD_PALL: req_ready = tick && ok[G_RAS] && ok[G_WR]
                             && !gap_bus.load[G_WR]
                             && ok[G_RD2PRE] && ok[G_WR2PRE];
         CMD_REF, CMD_MRS: req_ready = tick && ok[G_RC] && ok[G_RP];
         default: req_ready = 1'b0;
      endcase
   end
   // ****************************************************************
   // mode word and command pins
   // ****************************************************************
   logic [MODE_W-1:0] mode_word; // value for the mode register cycle
   assign mode_word = cas_latency_sel ? MODE_CL3 : MODE_CL2;
   // pins change on ticks only and hold for a whole memory cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {mem_ras_n, mem_cas_n, mem_we_n} <= PIN_NOP;
         mem_cs_n <= 1'b1;
         mem_ba <= 2'h0;
         mem_addr <= '0;
         precharge_addr_pin <= 1'b0;
      end else if (tick) begin
         mem_cs_n <= !(issue && req_cmd != CMD_NOP);
         case (issue ? req_cmd : CMD_NOP)
            CMD_ACT: begin
               {mem_ras_n, mem_cas_n, mem_we_n} <= PIN_ACT;
               mem_ba <= req_bank;
               mem_addr <= req_addr;
               precharge_addr_pin <= req_addr[MODE_A10_BIT];
            end
            CMD_RD, CMD_WR: begin
               {mem_ras_n, mem_cas_n, mem_we_n} <=
                  (req_cmd == CMD_RD) ? PIN_RD : PIN_WR;
               mem_ba <= req_bank;
               mem_addr <= req_addr;
               mem_addr[AUTOPRE_BIT] <= 1'b0;
               precharge_addr_pin <= 1'b0;
            end
            CMD_PRE, CMD_PALL: begin
               {mem_ras_n, mem_cas_n, mem_we_n} <= PIN_PRE;
               mem_ba <= req_bank;
               precharge_addr_pin <= (req_cmd == CMD_PALL);
            end
            CMD_REF: begin
               {mem_ras_n, mem_cas_n, mem_we_n} <= PIN_REF;
            end
            CMD_MRS: begin
               {mem_ras_n, mem_cas_n, mem_we_n} <= PIN_MRS;
               // bit n on pin n+2; bit 10 rides the precharge pin
               mem_addr <= AW'(mode_word);
               mem_addr[MODE_A10_BIT] <= 1'b0;
               precharge_addr_pin <= mode_word[MODE_A10_BIT];
            end
            default: begin
               {mem_ras_n, mem_cas_n, mem_we_n} <= PIN_NOP;
            end
         endcase
      end
   end
   // ****************************************************************
   // byte enables and read data timing
   // ****************************************************************
   // masked from each read until the next write, so the mask counter
   // covers the high time before a write may cut in
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         byte_enable_out <= 4'hF;
      end else if (is_rd) begin
         byte_enable_out <= 4'hF;
      end else if (is_wr) begin
         byte_enable_out <= 4'h0;
      end
   end
   logic [2:0] rd_pipe_q; // read issue delayed by ticks
   logic [2:0] cl_tap; // latency minus one, as a tap index
   assign cl_tap = CAS_BASE + 3'(cas_latency_sel) - 3'h1;
   // the tap moves with the select, so change it only while idle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_pipe_q <= 3'h0;
         rd_data_start <= 1'b0;
      end else begin
         rd_data_start <= tick && rd_pipe_q[cl_tap[1:0]];
         if (tick) begin
            rd_pipe_q <= {rd_pipe_q[1:0], is_rd};
         end
      end
   end
   // moves on ticks only, so the float never shows half a memory cycle early
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         read_bus_float <= 1'b1;
      end else if (tick) begin
         read_bus_float <= ok[G_HZP] && !gap_bus.load[G_HZP];
      end
   end
   // ****************************************************************
   // checks
   // ****************************************************************
   logic [5:0] since_q [5]; // ticks since ref, act, pre, rd, wr
   logic [4:0] hit; // which class issued now
   assign hit = {is_wr, is_rd, is_pre, is_act, is_ref};
   genvar k;
   generate
      for (k = 0; k < 5; k++) begin : since
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               since_q[k] <= 6'h3F;
            end else if (hit[k]) begin
               since_q[k] <= 6'h00;
            end else if (tick && since_q[k] != 6'h3F) begin
               since_q[k] <= since_q[k] + 6'h01;
            end
         end
      end
   endgenerate
   a_mode_value: assert property (@(posedge clk) disable iff (rst)
      is_mrs |=> mem_addr == ($past(cas_latency_sel) ? MODE_CL3 : MODE_CL2))
      else $error("mode word does not match latency select");
   a_mode_burst: assert property (@(posedge clk) disable iff (rst)
      is_mrs |=> mem_addr[2:0] == MODE_BL4 && !mem_addr[MODE_SI_BIT]
                 && !mem_ras_n == !mem_cas_n)
      else $error("mode word burst setting wrong");
   a_mode_lat: assert property (@(posedge clk) disable iff (rst)
      is_mrs |=> mem_addr[MODE_LAT_LSB] == $past(cas_latency_sel)
                 && mem_addr[MODE_LAT_LSB+2:MODE_LAT_LSB+1] == 2'h1)
      else $error("latency field wrong");
   a_refresh_gap: assert property (@(posedge clk) disable iff (rst)
      (is_act || is_mrs || is_ref) |-> since_q[0] >= 6'(refresh_cycle_field))
      else $error("refresh spacing broken");
   a_act_rdwr_gap: assert property (@(posedge clk) disable iff (rst)
      (is_rd || is_wr) |-> since_q[1] >= 6'(row_to_column_field))
      else $error("activate to column spacing broken");
   a_pre_act_gap: assert property (@(posedge clk) disable iff (rst)
      (is_act || is_mrs || is_ref) |-> since_q[2] >= 6'(precharge_field))
      else $error("precharge spacing broken");
   a_act_pre_gap: assert property (@(posedge clk) disable iff (rst)
      is_pre |-> since_q[1] >= 6'(row_active_field))
      else $error("row active spacing broken");
   a_act_act_gap: assert property (@(posedge clk) disable iff (rst)
      is_act |-> since_q[1] >= 6'(row_to_row_field) + 6'h01)
      else $error("row to row spacing broken");
   a_rd_wr_gap: assert property (@(posedge clk) disable iff (rst)
      is_wr |-> since_q[3] >= 6'(read_to_write_field)
                && since_q[3] >= 6'(byte_mask_turnaround_field))
      else $error("read to write spacing broken");
   a_wr_rd_gap: assert property (@(posedge clk) disable iff (rst)
      is_rd |-> since_q[4] >= 6'(write_to_read_field))
      else $error("write to read spacing broken");
   a_autopre_low: assert property (@(posedge clk) disable iff (rst)
      (is_rd || is_wr) |=> !mem_addr[AUTOPRE_BIT] && !precharge_addr_pin)
      else $error("auto-precharge pin high on column command");
   c_mode_cl3: cover property (@(posedge clk) is_mrs && cas_latency_sel);
   c_act_then_rd: cover property (@(posedge clk) is_act ##[1:40] is_rd);
   c_rd_then_wr: cover property (@(posedge clk) is_rd ##[1:40] is_wr);
   c_refresh: cover property (@(posedge clk) is_ref ##[1:40] is_act);
endmodule
`default_nettype wire

// >>> tb/sdmct_sdram_model.sv
// Purpose: listening sdram model that decodes commands from the pins
// Assumes: one command per memory clock period, pins steady for a period
// Notes: gap is counted in memory clock cycles between the last two commands
`timescale 1ns/1ps
`default_nettype none
module sdmct_sdram_model import sdmct_pkg::*; (
   input wire logic clk,
   input wire logic mclk,
   input wire logic cs_n,
   input wire logic [2:0] pins,
   input wire logic [13:0] addr,
   input wire logic pre_pin,
   output logic [13:0] last_addr,
   output logic [13:0] mode_q,
   output int gap
);
   logic mclk_q = 1'b0; // memory clock at the previous falling core edge
   int since = 0; // memory cycles since the last command
   // ********************************
   // one sample per memory cycle
   // ********************************
   initial begin
      last_addr = 14'h0;
      mode_q = 14'h0;
      gap = 0;
   end
   // the falling core edge keeps clear of the launch edge of the pins
   always @(negedge clk) begin
      mclk_q <= mclk;
      if (mclk === 1'b1 && mclk_q === 1'b0) begin
         since <= since + 1;
         if (cs_n === 1'b0) begin
            gap <= since + 1;
            since <= 0;
            last_addr <= addr;
            // mode bit n on pin n+2, bit ten on its own pin
            if (pins == PIN_MRS) begin
               mode_q <= {addr[13:11], pre_pin, addr[9:0]};
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/sdram_mode_and_command_timing_test.sv
// Purpose: self-checking bench for sdram mode and command timing
// Assumes: memory clock divide of two, timing fields held as levels
// Notes: each pair starts from idle so one field governs its gap
`timescale 1ns/1ps
`default_nettype none
module sdram_mode_and_command_timing_test;
   import sdmct_pkg::*;
   logic clk = 1'b0; // core clock
   logic rst = 1'b1; // reset, held at start
   logic req_valid = 1'b0; // command offered
   sdmct_cmd_t req_cmd = CMD_NOP; // command code
   logic wr_last_data = 1'b0; // last write data pulse
   logic cas_latency_sel = 1'b0; // zero gives latency two
   logic [3:0] fld [NGAP] = '{default: 4'h0}; // fields by counter index
   logic req_ready, mclk, cs_n, ras_n, cas_n, we_n, pre_pin, rds, flt;
   logic [1:0] ba; // bank pins
   logic [13:0] addr, last_addr, mode_q; // pins and model views
   logic [3:0] be; // byte enables
   int gap; // memory cycles between the last two commands
   int bad_count = 0; // mismatches
   int num_checks = 0; // comparisons
   time rel_t = 0; // when the last request was released
   // ********************************
   // command pairs and governing field
   // ********************************
   sdmct_cmd_t pa [14] = '{CMD_REF, CMD_REF, CMD_PRE, CMD_PALL, CMD_ACT,
      CMD_ACT, CMD_ACT, CMD_ACT, CMD_RD, CMD_RD, CMD_RD, CMD_WR, CMD_WR,
      CMD_WR};
   sdmct_cmd_t pb [14] = '{CMD_ACT, CMD_REF, CMD_ACT, CMD_MRS, CMD_RD,
      CMD_WR, CMD_PRE, CMD_ACT, CMD_RD, CMD_PRE, CMD_WR, CMD_WR, CMD_PALL,
      CMD_RD};
   int pf [14] = '{G_RC, G_RC, G_RP, G_RP, // refresh, precharge
      G_RCD, G_RCD, G_RAS, G_RRD, // activate
      G_READ_TO_READ_FIELD, G_RD2PRE, G_READ_TO_WRITE_FIELD, // read
      G_WRITE_TO_WRITE_FIELD, G_WR2PRE, G_WRITE_TO_READ_FIELD}; // write
   always #5 clk = ~clk;
   sdmct_top dut_u (.clk(clk), .rst(rst), .req_valid(req_valid),
      .req_cmd(req_cmd), .req_bank(2'h1), .req_addr(14'h3FFF),
      .req_ready(req_ready), .wr_last_data(wr_last_data),
      .cas_latency_sel(cas_latency_sel),
      .refresh_cycle_field(fld[G_RC]), .row_to_column_field(fld[G_RCD]),
      .precharge_field(fld[G_RP]), .row_active_field(fld[G_RAS]),
      .row_to_row_field(fld[G_RRD]), .write_recovery_field(fld[G_WR]),
      .precharge_float_field(fld[G_HZP]),
      .read_to_read_field(fld[G_READ_TO_READ_FIELD]),
      .read_to_precharge_field(fld[G_RD2PRE]),
      .read_to_write_field(fld[G_READ_TO_WRITE_FIELD]),
      .byte_mask_turnaround_field(fld[G_DQM]),
      .write_to_write_field(fld[G_WRITE_TO_WRITE_FIELD]),
      .write_to_precharge_field(fld[G_WR2PRE]),
      .write_to_read_field(fld[G_WRITE_TO_READ_FIELD]), .memory_clock_out(mclk),
      .mem_cs_n(cs_n), .mem_ras_n(ras_n), .mem_cas_n(cas_n),
      .mem_we_n(we_n), .mem_ba(ba), .mem_addr(addr),
      .precharge_addr_pin(pre_pin), .byte_enable_out(be),
      .rd_data_start(rds), .read_bus_float(flt));
   sdmct_sdram_model model_u (.clk(clk), .mclk(mclk), .cs_n(cs_n),
      .pins({ras_n, cas_n, we_n}), .addr(addr), .pre_pin(pre_pin),
      .last_addr(last_addr), .mode_q(mode_q), .gap(gap));
   // ********************************
   // tasks
   // ********************************
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // land just after an edge so inputs never race the design
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // hold the request until an edge sees ready high, bounded
   task automatic issue(input sdmct_cmd_t c);
      logic ok;
      int n;
      // let an edge pass after a release so no signal is set twice at once
      if ($time == rel_t)
         step(1);
      ok = 1'b0;
      n = 0;
      req_cmd = c;
      req_valid = 1'b1;
      while (!ok && n < 100) begin
         #8;
         ok = (req_ready === 1'b1);
         step(1);
         n++;
      end
      req_valid = 1'b0;
      req_cmd = CMD_NOP;
      rel_t = $time;
      check({15'h0, ok}, 16'h1);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ********************************
   // main sequence
   // ********************************
   initial begin
      int n;
      int g;
      step(8);
      check({be, 11'h0, flt}, 16'hF001); // idle levels held in reset
      rst = 1'b0;
      // mode word and read latency for both latency selects
      for (int s = 0; s < 2; s++) begin
         cas_latency_sel = s[0];
         step(40);
         issue(CMD_MRS);
         step(4);
         check(16'(mode_q), s ? 16'h0032 : 16'h0022);
         check(16'(mode_q[6:3]), 16'(4 + 2 * s));
         check(16'({mode_q[9], mode_q[2:0]}), 16'h2);
         step(40);
         issue(CMD_RD);
         n = 0;
         while (rds !== 1'b1 && n < 50) begin
            step(1);
            n++;
         end
         check(16'(n), 16'((s + 2) * 2));
      end
      // two field sets so that byte mask and read-to-write swap lead
      for (int s = 0; s < 2; s++) begin
         for (int i = 0; i < NGAP; i++)
            fld[i] = 4'((s == 0) ? (i * 3) % 7 : (i * 5) % 9);
         for (int p = 0; p < 14; p++) begin
            step(40);
            issue(pa[p]);
            issue(pb[p]);
            step(4);
            g = fld[pf[p]] + ((pf[p] == G_RRD) ? 2 : 1);
            if (pf[p] == G_READ_TO_WRITE_FIELD && fld[G_DQM] > fld[G_READ_TO_WRITE_FIELD])
               g = fld[G_DQM] + 1;
            check(16'(gap), 16'(g));
            if (pb[p] inside {CMD_RD, CMD_WR}) begin
               check(16'(last_addr), 16'h3BFF);
               check(16'({be, 2'h0, ba}),
                  (pb[p] == CMD_WR) ? 16'h01 : 16'hF1);
            end
         end
      end
      // write recovery holds a precharge, then the read bus floats
      step(40);
      issue(CMD_MRS);
      wr_last_data = 1'b1;
      step(1);
      wr_last_data = 1'b0;
      issue(CMD_PRE);
      step(4);
      check(16'(gap), 16'(fld[G_WR] + 2));
      step(40);
      issue(CMD_PRE);
      n = 0;
      while (flt !== 1'b0 && n < 4) begin
         step(1);
         n++;
      end
      n = 0;
      while (flt === 1'b0 && n < 60) begin
         step(1);
         n++;
      end
      check(16'(n), 16'((fld[G_HZP] + 1) * 2));
      print_verdict();
   end
   // watchdog well beyond the expected run of some eighteen microseconds
   initial begin
      #300000;
      bad_count++;
      print_verdict();
   end
endmodule
`default_nettype wire
